// ===== rtl/rfpm_consts.svh
// Register map, field positions, reset values and serial frame sizes
`ifndef RFPM_CONSTS_SVH
`define RFPM_CONSTS_SVH

`define RFPM_ADDR_W          6
`define RFPM_DATA_W          16
`define RFPM_CTRL_B_ADDR     6'h07
`define RFPM_CTRL_B_RST      16'h0000
`define RFPM_BIT_PORT_MODE   12
`define RFPM_BIT_BIAS_INV    13
`define RFPM_BIT_BIAS_EN     14
`define RFPM_HDR_BITS        4'h8
`define RFPM_DATA_BITS       4'hF
`define RFPM_HDR_RW_BIT      7
`define RFPM_SYNC_W          3

`endif

// ===== rtl/rfpm_pkg.sv
// Types shared by the port mode and bias control block
`default_nettype none
package rfpm_pkg;

    typedef enum logic [2:0] {
        RADIO_OFF       = 3'h0,
        RADIO_IDLE      = 3'h1,
        RADIO_RX        = 3'h2,
        RADIO_TX        = 3'h3,
        RADIO_DOZE      = 3'h4,
        RADIO_HIBERNATE = 3'h5
    } rfpm_radio_t;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'h0,
        SPI_HDR  = 2'h1,
        SPI_DATA = 2'h2,
        SPI_DONE = 2'h3
    } rfpm_spi_state_t;

endpackage

`default_nettype wire

// ===== rtl/rfpm_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module rfpm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk, // System clock
    input  wire logic             rst,     // Async reset, active high
    input  wire logic [WIDTH-1:0] d,       // Asynchronous inputs
    output logic      [WIDTH-1:0] q        // Synchronised outputs
);

    logic [WIDTH-1:0] meta_q;

    // Idle level of the serial pins is high for select, low for others
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/rfpm_top.sv
// RF port mode selection and switched bias output control with its serial register port
`timescale 1ns/1ps
`default_nettype none
`include "rfpm_consts.svh"

module rfpm_top (
    input  wire logic                 sys_clk,            // 20 MHz system clock
    input  wire logic                 rst,                // Async reset, active high
    input  wire logic                 spi_ce_n,           // Serial chip enable, active low
    input  wire logic                 spi_sclk,           // Serial clock
    input  wire logic                 spi_mosi,           // Serial data in
    output logic                      spi_miso,           // Serial data out
    input  wire rfpm_pkg::rfpm_radio_t radio_state,        // Current radio state
    output logic                      switched_bias_out,  // Bias pin output value
    output logic                      switched_bias_oe_n, // Bias pin enable, low drives
    output logic                      rx_switch_en,       // Internal RX switch to LNA
    output logic                      shared_pa_en,       // PA on shared RF pins
    output logic                      out_pa_en,          // PA on separate output pair
    output logic                      port_single         // 1 = single-port mode
);

    // Serial pin synchronisation
    logic [`RFPM_SYNC_W-1:0] pins_s;
    logic                    ce_n_s;
    logic                    sclk_s;
    logic                    mosi_s;
    logic                    sclk_d_q;
    logic                    sclk_rise;
    logic                    sclk_fall;

    rfpm_sync #(
        .WIDTH (`RFPM_SYNC_W)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({~spi_ce_n, spi_sclk, spi_mosi}),
        .q       (pins_s)
    );

    // Select is carried inverted so the synchroniser resets to deselected
    assign ce_n_s = ~pins_s[2];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_q;
    assign sclk_fall = ~sclk_s & sclk_d_q;

    // Serial frame: 8-bit header (bit 7 read, bits 5:0 address), 16 data bits
    rfpm_pkg::rfpm_spi_state_t spi_state_q;
    logic [3:0]                bit_cnt_q;
    logic [7:0]                hdr_sh_q;
    logic [`RFPM_DATA_W-1:0]   rx_sh_q;
    logic [`RFPM_DATA_W-1:0]   tx_sh_q;
    logic                      is_read_q;
    logic [`RFPM_ADDR_W-1:0]   addr_q;
    logic [7:0]                hdr_next;
    logic [`RFPM_DATA_W-1:0]   rx_next;
    logic                      hit_hdr;
    logic                      commit;
    logic [`RFPM_DATA_W-1:0]   ctrl_q;

    assign hdr_next = {hdr_sh_q[6:0], mosi_s};
    assign rx_next  = {rx_sh_q[`RFPM_DATA_W-2:0], mosi_s};
    assign hit_hdr  = (hdr_next[`RFPM_ADDR_W-1:0] == `RFPM_CTRL_B_ADDR);
    assign commit   = (spi_state_q == rfpm_pkg::SPI_DATA) && sclk_rise && !ce_n_s
                      && (bit_cnt_q == `RFPM_DATA_BITS) && !is_read_q
                      && (addr_q == `RFPM_CTRL_B_ADDR);

    // Frame sequencing; deselect aborts any frame, a short write is dropped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            spi_state_q <= rfpm_pkg::SPI_IDLE;
            bit_cnt_q   <= 4'h0;
        end else if (ce_n_s) begin
            spi_state_q <= rfpm_pkg::SPI_IDLE;
            bit_cnt_q   <= 4'h0;
        end else begin
            unique case (spi_state_q)
                rfpm_pkg::SPI_IDLE: begin
                    spi_state_q <= rfpm_pkg::SPI_HDR;
                    bit_cnt_q   <= 4'h0;
                end
                rfpm_pkg::SPI_HDR: begin
                    if (sclk_rise) begin
                        if (bit_cnt_q == (`RFPM_HDR_BITS - 4'h1)) begin
                            spi_state_q <= rfpm_pkg::SPI_DATA;
                            bit_cnt_q   <= 4'h0;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                rfpm_pkg::SPI_DATA: begin
                    if (sclk_rise) begin
                        if (bit_cnt_q == `RFPM_DATA_BITS) begin
                            spi_state_q <= rfpm_pkg::SPI_DONE;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                rfpm_pkg::SPI_DONE: begin
                    spi_state_q <= rfpm_pkg::SPI_DONE;
                end
            endcase
        end
    end

    // Header capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hdr_sh_q  <= 8'h00;
            is_read_q <= 1'b0;
            addr_q    <= 6'h00;
        end else if (spi_state_q == rfpm_pkg::SPI_HDR && sclk_rise && !ce_n_s) begin
            hdr_sh_q <= hdr_next;
            if (bit_cnt_q == (`RFPM_HDR_BITS - 4'h1)) begin
                is_read_q <= hdr_next[`RFPM_HDR_RW_BIT];
                addr_q    <= hdr_next[`RFPM_ADDR_W-1:0];
            end
        end
    end

    // Write data shift
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_sh_q <= 16'h0000;
        end else if (spi_state_q == rfpm_pkg::SPI_DATA && sclk_rise && !ce_n_s) begin
            rx_sh_q <= rx_next;
        end
    end

    // Read data: loaded after the header, shifted out on falling edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_sh_q  <= 16'h0000;
            spi_miso <= 1'b0;
        end else if (ce_n_s) begin
            spi_miso <= 1'b0;
        end else if (spi_state_q == rfpm_pkg::SPI_HDR && sclk_rise
                     && bit_cnt_q == (`RFPM_HDR_BITS - 4'h1)) begin
            // Unmapped addresses read as zero
            tx_sh_q <= (hdr_next[`RFPM_HDR_RW_BIT] && hit_hdr) ? ctrl_q : 16'h0000;
        end else if (spi_state_q == rfpm_pkg::SPI_DATA && sclk_fall && is_read_q) begin
            spi_miso <= tx_sh_q[`RFPM_DATA_W-1];
            tx_sh_q  <= {tx_sh_q[`RFPM_DATA_W-2:0], 1'b0};
        end
    end

    // Control register; every bit is kept, only three steer this block
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `RFPM_CTRL_B_RST;
        end else if (commit) begin
            ctrl_q <= rx_next;
        end
    end

    logic mode_single;
    logic bias_en;
    logic bias_inv;
    logic is_tx;
    logic is_rx;

    assign mode_single = ctrl_q[`RFPM_BIT_PORT_MODE];
    assign bias_en     = ctrl_q[`RFPM_BIT_BIAS_EN];
    assign bias_inv    = ctrl_q[`RFPM_BIT_BIAS_INV];
    assign is_tx       = (radio_state == rfpm_pkg::RADIO_TX);
    assign is_rx       = (radio_state == rfpm_pkg::RADIO_RX);

    // Switched bias pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            switched_bias_out  <= 1'b0;
            switched_bias_oe_n <= 1'b1;
        end else if (!bias_en) begin
            switched_bias_out  <= 1'b0;
            switched_bias_oe_n <= 1'b1;
        end else begin
            switched_bias_oe_n <= 1'b0;
            if (!(is_tx || is_rx)) begin
                // Off is undefined on the pin; held low like the sleep states
                switched_bias_out <= 1'b0;
            end else if (mode_single) begin
                switched_bias_out <= is_tx;
            end else begin
                switched_bias_out <= is_tx ^ bias_inv;
            end
        end
    end

    // Internal RF path steering
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_switch_en <= 1'b0;
            shared_pa_en <= 1'b0;
            out_pa_en    <= 1'b0;
            port_single  <= 1'b0;
        end else begin
            port_single  <= mode_single;
            rx_switch_en <= is_rx;
            shared_pa_en <= mode_single && is_tx;
            out_pa_en    <= !mode_single && is_tx;
        end
    end

endmodule

`default_nettype wire

// ===== test/rfpm_bias_load.sv
// Far-side load on the bias pin: the level the balun or switch sees
`timescale 1ns/1ps
`default_nettype none
module rfpm_bias_load (
    input  wire logic sys_clk, // Clock
    input  wire logic drv,     // Driven value
    input  wire logic oe_n,    // Low drives
    output logic      pin_lvl  // Pin level
);
    logic last_q = 1'b0;
    always_ff @(posedge sys_clk) begin
        if (!oe_n) last_q <= drv;
    end
    // No pull on this pin, so a released pin must not look driven
    assign pin_lvl = oe_n ? !last_q : drv;
endmodule
`default_nettype wire

// ===== test/rfpm_top_props.sv
// Port-level checks of the port mode and bias control block
`timescale 1ns/1ps
`default_nettype none
module rfpm_props (
    input wire logic                  sys_clk,            // Clock
    input wire logic                  rst,                // Reset
    input wire rfpm_pkg::rfpm_radio_t radio_state,        // State
    input wire logic                  switched_bias_out,  // Pin value
    input wire logic                  switched_bias_oe_n, // Pin enable
    input wire logic                  rx_switch_en,       // RX switch
    input wire logic                  shared_pa_en,       // Shared PA
    input wire logic                  out_pa_en,          // Output PA
    input wire logic                  port_single         // Mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [1:0]            up_q;
    rfpm_pkg::rfpm_radio_t st_q;
    logic                  tx, rx, dual;
    // Apart from chk_reset_hiz and chk_pa_excl, checks only judge outputs once two edges have passed since reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) up_q <= 2'h0;
        else up_q <= {up_q[0], 1'b1};
    end
    always_ff @(posedge sys_clk) begin
        st_q <= radio_state;
    end
    assign tx = (st_q == rfpm_pkg::RADIO_TX);
    assign rx = (st_q == rfpm_pkg::RADIO_RX);
    assign dual = &up_q && !switched_bias_oe_n && !port_single;
    chk_reset_hiz: assert property ($fell(rst) |-> switched_bias_oe_n && !port_single)
        else $error("bias pin or mode wrong after reset");
    chk_rx_path: assert property (&up_q |-> rx_switch_en == rx)
        else $error("rx switch wrong");
    chk_shared_pa: assert property (&up_q |-> shared_pa_en == (port_single && tx))
        else $error("shared pa wrong");
    chk_output_pa: assert property (&up_q |-> out_pa_en == (!port_single && tx))
        else $error("output pa wrong");
    chk_pa_excl: assert property (!(rx_switch_en && (shared_pa_en || out_pa_en)))
        else $error("receive and transmit paths both on");
    chk_idle_low: assert property (&up_q && !switched_bias_oe_n && !(tx || rx) |-> !switched_bias_out)
        else $error("bias pin not low when idle");
    chk_single_lvl: assert property (&up_q && !switched_bias_oe_n && port_single && (tx || rx)
        |-> switched_bias_out == tx)
        else $error("single-port bias level wrong");
    chk_dual_toggle: assert property (dual && rx ##1 dual && tx |-> $changed(switched_bias_out))
        else $error("dual-port bias did not toggle");
    cover property (dual && tx);
    cover property (&up_q && !switched_bias_oe_n && port_single && tx);
    cover property (&up_q && !switched_bias_oe_n && !(tx || rx));
endmodule
bind rfpm_top rfpm_props u_props (.sys_clk, .rst, .radio_state, .switched_bias_out,
    .switched_bias_oe_n, .rx_switch_en, .shared_pa_en, .out_pa_en, .port_single);
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the port mode and bias control block
`timescale 1ns/1ps
`default_nettype none
`include "rfpm_consts.svh"
module tb_top;
    typedef struct packed {logic k; logic [15:0] v;} rfpm_note_t;
    logic clk = 1'b0, rst = 1'b1, ce_n = 1'b1, sclk = 1'b0, mosi = 1'b0;
    rfpm_pkg::rfpm_radio_t st = rfpm_pkg::RADIO_OFF;
    logic        miso, bo, boe, rxe, spa, opa, psg, pin;
    logic [15:0] rd, ctl;
    int          err_count = 0, cmp_count = 0;
    rfpm_note_t  q[$], note;
    event        res_ev;
    rfpm_top u_dut (.sys_clk(clk), .rst, .spi_ce_n(ce_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .radio_state(st), .switched_bias_out(bo), .switched_bias_oe_n(boe),
        .rx_switch_en(rxe), .shared_pa_en(spa), .out_pa_en(opa), .port_single(psg));
    rfpm_bias_load u_load (.sys_clk(clk), .drv(bo), .oe_n(boe), .pin_lvl(pin));
    initial forever #25 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Ten clocks a bit keeps both serial clock phases clear of the synchroniser
    task automatic frame(input logic [23:0] b, input int n);
        ce_n = 1'b0;
        cyc(4);
        for (int i = 0; i < n; i++) begin
            mosi = b[23-i];
            cyc(5);
            sclk = 1'b1;
            rd = {rd[14:0], miso};
            cyc(5);
            sclk = 1'b0;
        end
        cyc(5);
        ce_n = 1'b1;
        cyc(6);
    endtask
    task automatic rdw(input logic [5:0] a, input logic [15:0] e);
        frame({2'h2, a, 16'h0000}, 24);
        q.push_back({1'b1, e});
        -> res_ev;
    endtask
    task automatic chk(input logic [15:0] c, input rfpm_pkg::rfpm_radio_t s);
        logic tx, rx, on, sg, o;
        tx = (s == rfpm_pkg::RADIO_TX);
        rx = (s == rfpm_pkg::RADIO_RX);
        on = c[`RFPM_BIT_BIAS_EN];
        sg = c[`RFPM_BIT_PORT_MODE];
        o = on & (tx | rx) & (sg ? tx : tx ^ c[`RFPM_BIT_BIAS_INV]);
        st = s;
        cyc(2);
        q.push_back({1'b0, 9'h000, sg, !on, o, rx, sg & tx, !sg & tx, o});
        -> res_ev;
    endtask
    task automatic rep(input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_word(input logic [15:0] e);
        rep(e, rd);
    endtask
    task automatic cmp_pins(input logic [6:0] e);
        rep({9'h000, e}, {9'h000, psg, boe, bo, rxe, spa, opa, boe ? 1'b0 : pin});
    endtask
    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial forever begin
        @(res_ev);
        note = q.pop_front();
        if (note.k) cmp_word(note.v);
        else cmp_pins(note.v[6:0]);
    end
    initial begin
        cyc(20000);
        err_count++;
        give_verdict;
    end
    initial begin
        ctl = 16'($urandom(32'hE57F6CB9));
        cyc(8);
        rst = 1'b0;
        cyc(3);
        for (int s = 0; s < 6; s++) chk(16'h0000, rfpm_pkg::rfpm_radio_t'(s));
        rdw(`RFPM_CTRL_B_ADDR, `RFPM_CTRL_B_RST);
        $display("Test reset done");
        for (int m = 0; m < 8; m++) begin
            ctl = 16'($urandom);
            ctl[14:12] = m[2:0];
            frame({2'h0, `RFPM_CTRL_B_ADDR, ctl}, 24);
            for (int s = 0; s < 6; s++) chk(ctl, rfpm_pkg::rfpm_radio_t'(s));
            rdw(`RFPM_CTRL_B_ADDR, ctl);
        end
        $display("Test modes done");
        frame({2'h0, 6'h08, ~ctl}, 24);
        frame({2'h0, `RFPM_CTRL_B_ADDR, ~ctl}, 12);
        rdw(`RFPM_CTRL_B_ADDR, ctl);
        rdw(6'h08, 16'h0000);
        chk(ctl, rfpm_pkg::RADIO_TX);
        $display("Test refused frames done");
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        cyc(3);
        chk(16'h0000, rfpm_pkg::RADIO_TX);
        rdw(`RFPM_CTRL_B_ADDR, `RFPM_CTRL_B_RST);
        $display("Test second reset done");
        // Let the watcher take the last note before the verdict
        cyc(2);
        give_verdict;
    end
endmodule
`default_nettype wire
